// file: shared/itv_map.vh
// Summary of operation
// - Merge all peripheral requests into a single request to the CPU.
// - Each source gets one of seven priorities; ties follow natural order.
// - Primary table starts at 000004h; six traps plus 16 sources.
// - Each entry is fetched as a 24-bit routine address, then branched to.
// - Traps beat sources; lower vector wins among traps and equal-level sources; vector 0 beats all others.
// - Entry and return each take a fixed number of cycles.
// - Alternate table needs boot segment, config bit, runtime enable bit 8.
// - With alternate table on, every vector is fetched from it.
// - Alternate base is start of last boot segment page from its limit.
// - Alternate table only when boot segment spans at least two pages.
// - Reset clears registers and starts execution at address zero.
// - Both tables share the boot segment code protection.
// - Clock failure trap: vector 0, 0x000004, priority 15, control one bit 1.
// - Bad address trap: vector 1, 0x000006, priority 14, control one bit 3.
// - Hard traps vector 2 priority 13: double-bit error, gated software trap.
// - Stack trap: vector 3, 0x00000A, priority 12, control one bit 2.
// - Arithmetic causes share vector 4, priority 11, flag control one bit 4.
// - Accumulator A/B overflow: type bits 14/13, enables 10/9.
// - Catastrophic A/B, shift, divide: type 12,11,7,6; shared enable bit 8.
// - Soft traps vector 6 priority 9: flags 9, 8, 4, 0 of control three.
// - Vector slots 5 and 7 are reserved, never raised.
`ifndef ITV_MAP_VH
`define ITV_MAP_VH
// ==========================================
// Register byte offsets
`define ITV_OFF_CTL1   8'h00
`define ITV_OFF_CTL2   8'h04
`define ITV_OFF_CTL3   8'h08
`define ITV_OFF_CTL4   8'h0c
`define ITV_OFF_IEN    8'h10
`define ITV_OFF_IPRLO  8'h14
`define ITV_OFF_IPRHI  8'h18
`define ITV_OFF_IFLG   8'h1c
`define ITV_OFF_STAT   8'h20
// ==========================================
// Field positions
`define ITV_B1_OSC     1
`define ITV_B1_STK     2
`define ITV_B1_ADR     3
`define ITV_B1_MATH    4
`define ITV_B1_DIVZ    6
`define ITV_B1_SHFT    7
`define ITV_B1_CATEN   8
`define ITV_B1_OVBEN   9
`define ITV_B1_OVAEN   10
`define ITV_B1_CATB    11
`define ITV_B1_CATA    12
`define ITV_B1_OVB     13
`define ITV_B1_OVA     14
`define ITV_B2_ALTEN   8
`define ITV_B2_SWTEN   13
`define ITV_B3_PLL     0
`define ITV_B3_LOOP    4
`define ITV_B3_NVM     8
`define ITV_B3_BUS     9
`define ITV_B4_SWT     0
`define ITV_B4_DED     1
// ==========================================
// Vectors, trap priorities, table layout
`define ITV_TBL_START  24'h000004
`define ITV_VEC_OSC    8'h00
`define ITV_VEC_ADR    8'h01
`define ITV_VEC_HARD   8'h02
`define ITV_VEC_STK    8'h03
`define ITV_VEC_MATH   8'h04
`define ITV_VEC_SOFT   8'h06
`define ITV_VEC_IRQ0   8'h08
`define ITV_PRI_OSC    4'hf
`define ITV_PRI_ADR    4'he
`define ITV_PRI_HARD   4'hd
`define ITV_PRI_STK    4'hc
`define ITV_PRI_MATH   4'hb
`define ITV_PRI_SOFT   4'h9
`define ITV_PAGE_SHIFT 11
`define ITV_MIN_PAGES  13'h0002
`define ITV_NUM_SRC    16
// ==========================================
// Reset values
`define ITV_RST_WORD   16'h0000
`define ITV_RST_PC     24'h000000
`endif

// file: rtl/itv_ctrl.v
`include "itv_map.vh"
module itv_ctrl (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Peripheral requests
  input  wire [15:0] irqIn,
  // Trap events
  input  wire        oscFailEvt,
  input  wire        addrErrEvt,
  input  wire        dedErrEvt,
  input  wire        stackErrEvt,
  input  wire        ovfAEvt,
  input  wire        ovfBEvt,
  input  wire        catAEvt,
  input  wire        catBEvt,
  input  wire        shiftErrEvt,
  input  wire        divZeroEvt,
  input  wire        busAddrErrEvt,
  input  wire        nvmAddrErrEvt,
  input  wire        loopOvfEvt,
  input  wire        pllLossEvt,
  // Boot segment configuration
  input  wire        bootSegDefined,
  input  wire        altCfgProgrammed,
  input  wire [12:0] bootSegLimit,
  input  wire        bootSegProtect,
  // CPU side
  input  wire [2:0]  cpuIpl,
  output wire        cpuIrq,
  input  wire        cpuAck,
  input  wire        cpuRet,
  output reg  [7:0]  cpuVecNum,
  output reg  [3:0]  cpuVecPri,
  output reg  [23:0] memAddr,
  output reg         memRd,
  output reg         memProtect,
  input  wire [23:0] memData,
  output reg         cpuBranch,
  output reg  [23:0] cpuTarget,
  output reg         cpuRetDone
);

  // ==========================================
  // Functions
  function [3:0] regIdx;
    input [7:0] a;
    begin
      regIdx = (a[1:0] == 2'b00 && a[7:2] <= 6'h08) ? a[5:2] : 4'hf;
    end
  endfunction

  function [15:0] mergeWord;
    input [15:0] cur;
    input [31:0] d;
    input [3:0]  s;
    begin
      mergeWord = {s[1] ? d[15:8] : cur[15:8], s[0] ? d[7:0] : cur[7:0]};
    end
  endfunction

  function [2:0] srcPri;
    input [31:0] lo;
    input [31:0] hi;
    input [3:0]  n;
    reg   [63:0] all;
    begin
      all    = {hi, lo};
      srcPri = all[n*4 +: 3];
    end
  endfunction

  // ==========================================
  // State
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_FETCH = 7'h02;
  localparam [6:0] ST_WAIT  = 7'h04;
  localparam [6:0] ST_JUMP  = 7'h08;
  localparam [6:0] ST_SERVE = 7'h10;
  localparam [6:0] ST_RET1  = 7'h20;
  localparam [6:0] ST_RET2  = 7'h40;

  reg [15:0] ctl1_r;
  reg [15:0] ctl2_r;
  reg [15:0] ctl3_r;
  reg [15:0] ctl4_r;
  reg [15:0] ien_r;
  reg [31:0] iprLo_r;
  reg [31:0] iprHi_r;
  reg [15:0] iflg_r;
  reg [6:0]  state_r;
  reg [6:0]  state_nxt;
  reg        awHeld_r;
  reg        wHeld_r;
  reg [7:0]  awAddr_r;
  reg [31:0] wData_r;
  reg [3:0]  wStrb_r;
  reg [15:0] ctl1_nxt;
  reg [15:0] ctl3_nxt;
  reg [15:0] ctl4_nxt;
  reg [15:0] iflg_nxt;

  // ==========================================
  // AXI4-Lite handshake
  wire       doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire [3:0] wIdx    = regIdx(awAddr_r);
  wire [3:0] rIdx    = regIdx(s_axi_araddr);
  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      awHeld_r     <= 1'b0;
      wHeld_r      <= 1'b0;
      awAddr_r     <= 8'h00;
      wData_r      <= 32'h00000000;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wIdx == 4'hf) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
      end
    end
  end

  // ==========================================
  // Vector table selection
  wire altOn = bootSegDefined && altCfgProgrammed
               && ctl2_r[`ITV_B2_ALTEN]
               && (bootSegLimit >= `ITV_MIN_PAGES);
  wire [23:0] altBase = {11'h000, bootSegLimit - 13'h0001}
                        << `ITV_PAGE_SHIFT;
  wire [23:0] tblBase = altOn ? altBase : 24'h000000;

  // ==========================================
  // Trap ranking
  wire swTrap  = ctl4_r[`ITV_B4_SWT] && ctl2_r[`ITV_B2_SWTEN];
  wire hardPnd = ctl4_r[`ITV_B4_DED] || swTrap;
  wire softPnd = ctl3_r[`ITV_B3_BUS] || ctl3_r[`ITV_B3_NVM]
                 || ctl3_r[`ITV_B3_LOOP] || ctl3_r[`ITV_B3_PLL];
  wire trapPnd = ctl1_r[`ITV_B1_OSC] || ctl1_r[`ITV_B1_ADR] || hardPnd
                 || ctl1_r[`ITV_B1_STK] || ctl1_r[`ITV_B1_MATH] || softPnd;
  reg  [7:0] trapVec;
  reg  [3:0] trapPri;

  // Slots 5 and 7 never chosen
  always @* begin
    trapVec = `ITV_VEC_SOFT;
    trapPri = `ITV_PRI_SOFT;
    if (ctl1_r[`ITV_B1_OSC]) begin
      trapVec = `ITV_VEC_OSC;
      trapPri = `ITV_PRI_OSC;
    end else if (ctl1_r[`ITV_B1_ADR]) begin
      trapVec = `ITV_VEC_ADR;
      trapPri = `ITV_PRI_ADR;
    end else if (hardPnd) begin
      trapVec = `ITV_VEC_HARD;
      trapPri = `ITV_PRI_HARD;
    end else if (ctl1_r[`ITV_B1_STK]) begin
      trapVec = `ITV_VEC_STK;
      trapPri = `ITV_PRI_STK;
    end else if (ctl1_r[`ITV_B1_MATH]) begin
      trapVec = `ITV_VEC_MATH;
      trapPri = `ITV_PRI_MATH;
    end
  end

  // ==========================================
  // Peripheral ranking
  reg  [2:0] bestPri;
  reg  [3:0] bestIdx;
  reg  [2:0] curPri;
  integer    i;

  always @* begin
    bestPri = 3'h0;
    bestIdx = 4'h0;
    curPri  = 3'h0;
    for (i = `ITV_NUM_SRC - 1; i >= 0; i = i - 1) begin
      curPri = srcPri(iprLo_r, iprHi_r, i[3:0]);
      if (iflg_r[i] && ien_r[i] && curPri != 3'h0
          && curPri >= bestPri) begin
        bestPri = curPri;
        bestIdx = i[3:0];
      end
    end
  end

  wire irqPnd = (bestPri > cpuIpl);
  wire [7:0] winVec = trapPnd ? trapVec : `ITV_VEC_IRQ0 + {4'h0, bestIdx};
  wire [3:0] winPri = trapPnd ? trapPri : {1'b0, bestPri};
  assign cpuIrq = (trapPnd || irqPnd) && (state_r == ST_IDLE);

  // ==========================================
  // Register writes and flags
  always @* begin
    ctl1_nxt = ctl1_r;
    ctl3_nxt = ctl3_r;
    ctl4_nxt = ctl4_r;
    iflg_nxt = iflg_r;
    if (doWrite && wIdx == 4'h0)
      ctl1_nxt = mergeWord(ctl1_r, wData_r, wStrb_r);
    if (doWrite && wIdx == 4'h2)
      ctl3_nxt = mergeWord(ctl3_r, wData_r, wStrb_r);
    if (doWrite && wIdx == 4'h3)
      ctl4_nxt = mergeWord(ctl4_r, wData_r, wStrb_r);
    if (doWrite && wIdx == 4'h7)
      iflg_nxt = iflg_r & ~mergeWord(16'h0000, wData_r, wStrb_r);
    // Events win over a clear in the same cycle
    iflg_nxt = iflg_nxt | irqIn;
    if (oscFailEvt)
      ctl1_nxt[`ITV_B1_OSC] = 1'b1;
    if (addrErrEvt)
      ctl1_nxt[`ITV_B1_ADR] = 1'b1;
    if (stackErrEvt)
      ctl1_nxt[`ITV_B1_STK] = 1'b1;
    if (dedErrEvt)
      ctl4_nxt[`ITV_B4_DED] = 1'b1;
    if (ovfAEvt && ctl1_r[`ITV_B1_OVAEN]) begin
      ctl1_nxt[`ITV_B1_OVA]  = 1'b1;
      ctl1_nxt[`ITV_B1_MATH] = 1'b1;
    end
    if (ovfBEvt && ctl1_r[`ITV_B1_OVBEN]) begin
      ctl1_nxt[`ITV_B1_OVB]  = 1'b1;
      ctl1_nxt[`ITV_B1_MATH] = 1'b1;
    end
    if (ctl1_r[`ITV_B1_CATEN]) begin
      if (catAEvt)
        ctl1_nxt[`ITV_B1_CATA] = 1'b1;
      if (catBEvt)
        ctl1_nxt[`ITV_B1_CATB] = 1'b1;
      if (shiftErrEvt)
        ctl1_nxt[`ITV_B1_SHFT] = 1'b1;
      if (divZeroEvt)
        ctl1_nxt[`ITV_B1_DIVZ] = 1'b1;
      if (catAEvt || catBEvt || shiftErrEvt || divZeroEvt)
        ctl1_nxt[`ITV_B1_MATH] = 1'b1;
    end
    if (busAddrErrEvt)
      ctl3_nxt[`ITV_B3_BUS] = 1'b1;
    if (nvmAddrErrEvt)
      ctl3_nxt[`ITV_B3_NVM] = 1'b1;
    if (loopOvfEvt)
      ctl3_nxt[`ITV_B3_LOOP] = 1'b1;
    if (pllLossEvt)
      ctl3_nxt[`ITV_B3_PLL] = 1'b1;
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      ctl1_r  <= `ITV_RST_WORD;
      ctl2_r  <= `ITV_RST_WORD;
      ctl3_r  <= `ITV_RST_WORD;
      ctl4_r  <= `ITV_RST_WORD;
      ien_r   <= 16'h0000;
      iprLo_r <= 32'h00000000;
      iprHi_r <= 32'h00000000;
      iflg_r  <= 16'h0000;
    end else begin
      ctl1_r <= ctl1_nxt;
      ctl3_r <= ctl3_nxt;
      ctl4_r <= ctl4_nxt;
      iflg_r <= iflg_nxt;
      if (doWrite && wIdx == 4'h1)
        ctl2_r <= mergeWord(ctl2_r, wData_r, wStrb_r);
      if (doWrite && wIdx == 4'h4)
        ien_r <= mergeWord(ien_r, wData_r, wStrb_r);
      if (doWrite && wIdx == 4'h5)
        iprLo_r <= wData_r & 32'h77777777;
      if (doWrite && wIdx == 4'h6)
        iprHi_r <= wData_r & 32'h77777777;
    end
  end

  // ==========================================
  // Register reads
  always @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (rIdx == 4'hf) ? 2'b10 : 2'b00;
      case (rIdx)
        4'h0: s_axi_rdata <= {16'h0000, ctl1_r};
        4'h1: s_axi_rdata <= {16'h0000, ctl2_r};
        4'h2: s_axi_rdata <= {16'h0000, ctl3_r};
        4'h3: s_axi_rdata <= {16'h0000, ctl4_r};
        4'h4: s_axi_rdata <= {16'h0000, ien_r};
        4'h5: s_axi_rdata <= iprLo_r;
        4'h6: s_axi_rdata <= iprHi_r;
        4'h7: s_axi_rdata <= {16'h0000, iflg_r};
        4'h8: s_axi_rdata <= {9'h000, state_r, altOn, cpuIrq,
                              2'b00, cpuVecPri, cpuVecNum};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Entry and return sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (cpuAck && cpuIrq) state_nxt = ST_FETCH;
      ST_FETCH: state_nxt = ST_WAIT;
      ST_WAIT:  state_nxt = ST_JUMP;
      ST_JUMP:  state_nxt = ST_SERVE;
      ST_SERVE: if (cpuRet) state_nxt = ST_RET1;
      ST_RET1:  state_nxt = ST_RET2;
      ST_RET2:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      state_r    <= ST_IDLE;
      cpuVecNum  <= 8'h00;
      cpuVecPri  <= 4'h0;
      memAddr    <= 24'h000000;
      memRd      <= 1'b0;
      memProtect <= 1'b0;
      cpuBranch  <= 1'b0;
      cpuTarget  <= `ITV_RST_PC;
      cpuRetDone <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      memRd      <= 1'b0;
      cpuBranch  <= 1'b0;
      cpuRetDone <= 1'b0;
      if (state_r == ST_IDLE && state_nxt == ST_FETCH) begin
        cpuVecNum  <= winVec;
        cpuVecPri  <= winPri;
        memAddr    <= tblBase + `ITV_TBL_START
                      + {15'h0000, winVec, 1'b0};
        memRd      <= 1'b1;
        memProtect <= bootSegProtect;
      end
      if (state_r == ST_WAIT)
        cpuTarget <= memData;
      if (state_r == ST_JUMP)
        cpuBranch <= 1'b1;
      if (state_r == ST_RET2)
        cpuRetDone <= 1'b1;
    end
  end

endmodule

// file: verif/itv_mem_model.sv
module itv_mem_model (
  // Clock
  input  logic        ref_clk,
  // Vector fetch
  input  logic        memRd,
  input  logic [23:0] memAddr,
  output logic [23:0] memData
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Program memory holding routine addresses
  initial memData = 24'h000000;
  always @(posedge ref_clk) begin
    if (memRd)
      memData <= memAddr + 24'h100000;
    else
      memData <= ~memData;
  end
endmodule

// file: verif/itv_ctrl_checker.sv
`include "itv_map.vh"
module itv_ctrl_checker (
  // Clock and reset
  input logic        ref_clk,
  input logic        rstn,
  // Boot segment configuration
  input logic        bootSegDefined,
  input logic        altCfgProgrammed,
  input logic [12:0] bootSegLimit,
  input logic        bootSegProtect,
  // CPU side
  input logic [2:0]  cpuIpl,
  input logic        cpuIrq,
  input logic        cpuAck,
  input logic        cpuRet,
  input logic [7:0]  cpuVecNum,
  input logic [3:0]  cpuVecPri,
  input logic [23:0] memAddr,
  input logic        memRd,
  input logic        memProtect,
  input logic [23:0] memData,
  input logic        cpuBranch,
  input logic [23:0] cpuTarget,
  input logic        cpuRetDone
);
  // ==========================================
  // Trap priority by vector
  function automatic logic [3:0] trapPri(input logic [7:0] v);
    case (v)
      8'h00: return `ITV_PRI_OSC;
      8'h01: return `ITV_PRI_ADR;
      8'h02: return `ITV_PRI_HARD;
      8'h03: return `ITV_PRI_STK;
      8'h04: return `ITV_PRI_MATH;
      8'h06: return `ITV_PRI_SOFT;
      default: return 4'h0;
    endcase
  endfunction
  // ==========================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ack_fetch_a: assert property (cpuAck && cpuIrq |=> memRd && !cpuIrq)
    else $error("entry not started after acknowledge");
  entry_len_a: assert property (memRd |-> !cpuBranch [*3] ##1 cpuBranch)
    else $error("entry latency wrong");
  target_load_a: assert property (cpuBranch |-> cpuTarget == $past(memData, 2))
    else $error("branch target not fetched entry");
  entry_addr_a: assert property (memRd |->
    (memAddr & 24'h0007ff) == `ITV_TBL_START + {15'h0, cpuVecNum, 1'b0})
    else $error("entry offset wrong");
  primary_only_a: assert property (memRd && !(bootSegDefined && altCfgProgrammed &&
    bootSegLimit >= 13'h0002) |-> memAddr[23:11] == 13'h0000)
    else $error("alternate table used while not allowed");
  alt_base_a: assert property (memRd && memAddr[23:11] != 13'h0000 |->
    memAddr[23:11] == bootSegLimit - 13'h0001)
    else $error("alternate base wrong");
  protect_copy_a: assert property (memRd |-> memProtect == bootSegProtect)
    else $error("fetch protection wrong");
  trap_pri_a: assert property (memRd && cpuVecNum < `ITV_VEC_IRQ0 |->
    cpuVecPri == trapPri(cpuVecNum) && cpuVecNum != 8'h05 && cpuVecNum != 8'h07)
    else $error("trap vector or priority wrong");
  irq_level_a: assert property (memRd && cpuVecNum >= `ITV_VEC_IRQ0 |->
    cpuVecPri inside {[4'h1:4'h7]} && cpuVecPri[2:0] > $past(cpuIpl))
    else $error("interrupt level wrong");
  ret_len_a: assert property (cpuRetDone |-> $past(cpuRet, 3))
    else $error("return latency wrong");
  reset_clear_a: assert property ($rose(rstn) |->
    cpuTarget == `ITV_RST_PC && !cpuIrq && !cpuBranch)
    else $error("state not cleared by reset");
  cover property (memRd && cpuVecNum == 8'h00);
  cover property (memRd && memAddr[23:11] != 13'h0000);
  cover property (memRd && cpuVecNum >= `ITV_VEC_IRQ0);
  cover property (cpuRetDone);
endmodule

bind itv_ctrl itv_ctrl_checker itv_ctrl_checker_inst (.*);

// file: verif/itv_ctrl_tb.sv
`include "itv_map.vh"
module itv_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Signals
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] irqIn = 16'h0;
  logic [13:0] ev = 14'h0;
  logic        bootSegDefined = 1'b0, altCfgProgrammed = 1'b0, bootSegProtect = 1'b0;
  logic [12:0] bootSegLimit = 13'h0;
  logic [2:0]  cpuIpl = 3'h0;
  logic        cpuAck = 1'b0, cpuRet = 1'b0;
  logic        cpuIrq, memRd, memProtect, cpuBranch, cpuRetDone;
  logic [7:0]  cpuVecNum;
  logic [3:0]  cpuVecPri;
  logic [23:0] memAddr, memData, cpuTarget;
  int          n_errors = 0, tests_run = 0, cyc = 0;
  logic [7:0]  tv [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
  logic [3:0]  tp [6] = '{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'h9};
  logic [7:0]  ta [6] = '{8'h00, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h08};
  logic [31:0] td [6] = '{32'h7fdc, 32'h7fd4, 32'h0, 32'h7fd0, 32'h7fc0, 32'h0};

  always #50 ref_clk = ~ref_clk;
  // ==========================================
  // Design and far side
  itv_ctrl itv_ctrl_inst (
    .oscFailEvt(ev[0]), .addrErrEvt(ev[1]), .dedErrEvt(ev[2]), .stackErrEvt(ev[3]),
    .ovfAEvt(ev[4]), .ovfBEvt(ev[5]), .catAEvt(ev[6]), .catBEvt(ev[7]),
    .shiftErrEvt(ev[8]), .divZeroEvt(ev[9]), .busAddrErrEvt(ev[10]),
    .nvmAddrErrEvt(ev[11]), .loopOvfEvt(ev[12]), .pllLossEvt(ev[13]), .*);
  itv_mem_model itv_mem_model_inst (.ref_clk(ref_clk), .memRd(memRd), .memAddr(memAddr),
    .memData(memData));
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int t = 0; t < 100; t++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int t = 0; t < 100; t++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    s_axi_rready <= 1'b0;
    chk(d, ed);
    chk({s_axi_rvalid, r}, {1'b1, er});
  endtask
  task automatic pulse(input logic [13:0] e, input logic [15:0] q);
    @(posedge ref_clk);
    ev <= e;
    irqIn <= q;
    @(posedge ref_clk);
    ev <= 14'h0;
    irqIn <= 16'h0;
  endtask
  task automatic irqIs(input logic v);
    @(negedge ref_clk);
    chk(cpuIrq, v);
  endtask
  task automatic enter(input logic [7:0] v, input logic [3:0] p, input logic [23:0] b);
    logic [23:0] a;
    a = b + `ITV_TBL_START + {15'h0, v, 1'b0};
    irqIs(1'b1);
    @(posedge ref_clk);
    cpuAck <= 1'b1;
    @(posedge ref_clk);
    cpuAck <= 1'b0;
    @(negedge ref_clk);
    chk({memRd, memAddr}, {1'b1, a});
    chk({cpuVecNum, cpuVecPri}, {v, p});
    chk(memProtect, bootSegProtect);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({cpuBranch, cpuTarget}, {1'b1, a + 24'h100000});
    @(posedge ref_clk);
    cpuRet <= 1'b1;
    @(posedge ref_clk);
    cpuRet <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(cpuRetDone, 1'b1);
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    chk(cpuTarget, `ITV_RST_PC);
    irqIs(1'b0);
    rd(`ITV_OFF_CTL1, 32'h0, 2'b00);
    rd(`ITV_OFF_STAT, 32'h00010000, 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    wr(8'h44, 32'h1, 2'b10);
    $display("reset test done");
  endtask
  task t_gate;
    pulse(14'h03f0, 16'h0);
    rd(`ITV_OFF_CTL1, 32'h0, 2'b00);
    irqIs(1'b0);
    $display("gating test done");
  endtask
  task t_traps;
    wr(`ITV_OFF_CTL1, 32'h0700, 2'b00);
    pulse(14'h3fff, 16'h0);
    rd(`ITV_OFF_CTL1, 32'h7fde, 2'b00);
    rd(`ITV_OFF_CTL3, 32'h0311, 2'b00);
    rd(`ITV_OFF_CTL4, 32'h0002, 2'b00);
    for (int i = 0; i < 6; i++) begin
      enter(tv[i], tp[i], 24'h0);
      wr(ta[i], td[i], 2'b00);
    end
    irqIs(1'b0);
    wr(`ITV_OFF_CTL4, 32'h1, 2'b00);
    irqIs(1'b0);
    wr(`ITV_OFF_CTL2, 32'h2000, 2'b00);
    enter(8'h02, 4'hd, 24'h0);
    wr(`ITV_OFF_CTL4, 32'h0, 2'b00);
    $display("trap test done");
  endtask
  task t_irq;
    cpuIpl <= 3'h4;
    wr(`ITV_OFF_IEN, 32'h1208, 2'b00);
    wr(`ITV_OFF_IPRLO, 32'h00005000, 2'b00);
    wr(`ITV_OFF_IPRHI, 32'h00070050, 2'b00);
    pulse(14'h0, 16'h1208);
    rd(`ITV_OFF_IFLG, 32'h1208, 2'b00);
    enter(8'h14, 4'h7, 24'h0);
    wr(`ITV_OFF_IFLG, 32'h1000, 2'b00);
    enter(8'h0b, 4'h5, 24'h0);
    @(posedge ref_clk);
    bootSegDefined <= 1'b1;
    altCfgProgrammed <= 1'b1;
    bootSegLimit <= 13'h3;
    bootSegProtect <= 1'b1;
    wr(`ITV_OFF_CTL2, 32'h0100, 2'b00);
    enter(8'h0b, 4'h5, 24'h001000);
    @(posedge ref_clk);
    bootSegLimit <= 13'h1;
    enter(8'h0b, 4'h5, 24'h0);
    @(posedge ref_clk);
    cpuIpl <= 3'h5;
    irqIs(1'b0);
    wr(`ITV_OFF_IFLG, 32'h1208, 2'b00);
    rd(`ITV_OFF_IFLG, 32'h0, 2'b00);
    $display("interrupt test done");
  endtask
  task t_midreset;
    pulse(14'h0001, 16'h0);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk(cpuTarget, `ITV_RST_PC);
    irqIs(1'b0);
    rd(`ITV_OFF_CTL1, 32'h0, 2'b00);
    $display("mid-run reset test done");
  endtask
  // ==========================================
  // Run control
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_gate();
    t_traps();
    t_irq();
    t_midreset();
    summarize();
  end
endmodule
